// ==== tap_pkg.sv ====
package tap_pkg;

   localparam int N_POS     = 124;
   localparam int CHAIN_LEN = 344;
   localparam int IR_LEN    = 3;
   localparam int ID_LEN    = 32;

   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_INTEST = 3'h1;
   localparam logic [2:0] IR_SAMPLE = 3'h2;
   localparam logic [2:0] IR_IDCODE = 3'h3;
   localparam logic [2:0] IR_BYPASS = 3'h7;
   localparam logic [2:0] IR_CAP    = 3'h1;

   // Cell slot within one chain position, nearest the data input first
   localparam int CELL_IN  = 0;
   localparam int CELL_OUT = 1;
   localparam int CELL_EN  = 2;

   typedef enum logic [3:0] {
      ST_EXIT2_DR  = 4'h0,
      ST_EXIT1_DR  = 4'h1,
      ST_SHIFT_DR  = 4'h2,
      ST_PAUSE_DR  = 4'h3,
      ST_SEL_IR    = 4'h4,
      ST_UPDATE_DR = 4'h5,
      ST_CAPTURE_DR= 4'h6,
      ST_SEL_DR    = 4'h7,
      ST_EXIT2_IR  = 4'h8,
      ST_EXIT1_IR  = 4'h9,
      ST_SHIFT_IR  = 4'hA,
      ST_PAUSE_IR  = 4'hB,
      ST_IDLE      = 4'hC,
      ST_UPDATE_IR = 4'hD,
      ST_CAPTURE_IR= 4'hE,
      ST_RESET     = 4'hF
   } tap_state_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } tap_pins_t;

   // Positions that carry a single input cell; every other one has three
   function automatic logic is_in_only(input int p);
      case (p)
         17, 18, 87, 93, 94, 98, 107, 108, 117, 118, 121, 122, 123, 124: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : is_in_only

   function automatic int pos_cells(input int p);
      return is_in_only(p) ? 1 : 3;
   endfunction : pos_cells

   function automatic int pos_base(input int p);
      int s;
      s = 0;
      for (int i = 1; i < p; i++) s += pos_cells(i);
      return s;
   endfunction : pos_base

   // Constant per position as {in, out, enable}
   function automatic logic [2:0] pos_init(input int p);
      case (p)
         1, 5:    return 3'h1;
         2, 9:    return 3'h4;
         6:       return 3'h7;
         11:      return 3'h6;
         default: return 3'h0;
      endcase
   endfunction : pos_init

   // Chain bit index: 0 sits at the data output end
   function automatic int cell_idx(input int p, input int k);
      return CHAIN_LEN - 1 - pos_base(p) - k;
   endfunction : cell_idx

endpackage : tap_pkg

// ==== scan_tap.sv ====
`timescale 1ns/1ps
module scan_tap
   import tap_pkg::*;
#(
   parameter logic [3:0]  ID_VERSION = 4'h1,      // Arbitrary value
   parameter logic [15:0] ID_DEVICE  = 16'h5A5A,  // Arbitrary value
   parameter logic [10:0] ID_MAKER   = 11'h123    // Arbitrary value
)(
   input  wire logic                i_mclk,     // System clock
   input  wire logic                i_rst,      // Power-on reset, sync high
   input  wire tap_pins_t           i_jtag,     // Test clock, mode, data in
   input  wire logic [N_POS-1:0]    i_pin_in,   // Pad input levels
   input  wire logic [N_POS-1:0]    i_core_do,  // Core output data
   input  wire logic [N_POS-1:0]    i_core_oe,  // Core output enable
   output logic                     o_tdo,      // Test data out
   output logic                     o_tdo_oe,   // Test data out enable
   output logic [N_POS-1:0]         o_pin_do,   // Pad output data
   output logic [N_POS-1:0]         o_pin_oe,   // Pad output enable
   output logic [N_POS-1:0]         o_core_di,  // Level seen by core
   output logic                     o_test_mode // Pins owned by the chain
);

   // ---------------------------------------------------------------
   // Pin synchronisers and test clock edges
   // ---------------------------------------------------------------
   tap_pins_t           jt_s1_q, jt_s2_q;
   logic                tck_q;
   logic [N_POS-1:0]    pin_s1_q, pin_s2_q;
   logic                tck_rise, tck_fall;

   // Pad levels pass two flops as well; captured levels lag the pins by two clocks
   always_ff @(posedge i_mclk)
   begin
      jt_s1_q  <= i_jtag;
      jt_s2_q  <= jt_s1_q;
      pin_s1_q <= i_pin_in;
      pin_s2_q <= pin_s1_q;
   end

   // Test clock high and low phases must each last at least one system clock or an
   // edge is lost; this bounds the usable test clock rate.
   // Follows the synced pin through reset too, so no false edge follows release
   always_ff @(posedge i_mclk)
   begin
      tck_q <= jt_s2_q.tck;
   end

   assign tck_rise = jt_s2_q.tck & ~tck_q;
   assign tck_fall = ~jt_s2_q.tck & tck_q;

   // ---------------------------------------------------------------
   // Controller
   // ---------------------------------------------------------------
   tap_state_t state_q, state_d;
   logic       tms;

   assign tms = jt_s2_q.tms;

   // Mode select passes the same two flops as the test clock, so the level read
   // at a synced rise is the one that stood at the pin's rise
   always_comb
   begin
      unique case (state_q)
         ST_RESET:      state_d = tms ? ST_RESET     : ST_IDLE;
         ST_IDLE:       state_d = tms ? ST_SEL_DR    : ST_IDLE;
         ST_SEL_DR:     state_d = tms ? ST_SEL_IR    : ST_CAPTURE_DR;
         ST_CAPTURE_DR: state_d = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
         ST_SHIFT_DR:   state_d = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
         ST_EXIT1_DR:   state_d = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
         ST_PAUSE_DR:   state_d = tms ? ST_EXIT2_DR  : ST_PAUSE_DR;
         ST_EXIT2_DR:   state_d = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
         ST_UPDATE_DR:  state_d = tms ? ST_SEL_DR    : ST_IDLE;
         ST_SEL_IR:     state_d = tms ? ST_RESET     : ST_CAPTURE_IR;
         ST_CAPTURE_IR: state_d = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
         ST_SHIFT_IR:   state_d = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
         ST_EXIT1_IR:   state_d = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
         ST_PAUSE_IR:   state_d = tms ? ST_EXIT2_IR  : ST_PAUSE_IR;
         ST_EXIT2_IR:   state_d = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
         ST_UPDATE_IR:  state_d = tms ? ST_SEL_DR    : ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         state_q <= ST_RESET;
      else if (tck_rise)
         state_q <= state_d;
   end

   // ---------------------------------------------------------------
   // Instruction register
   // ---------------------------------------------------------------
   logic [IR_LEN-1:0] ir_sh_q, ir_q;

   // Capture and shift work on the shift stage only; the decoder sees the
   // updated code, never a partly shifted one
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         ir_sh_q <= IR_IDCODE;
         ir_q    <= IR_IDCODE;
      end
      else if (state_q == ST_RESET)
      begin
         ir_sh_q <= IR_IDCODE;
         ir_q    <= IR_IDCODE;
      end
      else if (tck_rise)
      begin
         unique case (state_q)
            ST_CAPTURE_IR: ir_sh_q <= IR_CAP;
            ST_SHIFT_IR:   ir_sh_q <= {jt_s2_q.tdi, ir_sh_q[IR_LEN-1:1]};
            ST_UPDATE_IR:  ir_q    <= ir_sh_q;
            default:       ir_sh_q <= ir_sh_q;
         endcase
      end
   end

   logic sel_extest, sel_intest, sel_sample, sel_idcode, sel_bypass;

   // Any code not listed falls through to bypass
   assign sel_extest = (ir_q == IR_EXTEST);
   assign sel_intest = (ir_q == IR_INTEST);
   assign sel_sample = (ir_q == IR_SAMPLE);
   assign sel_idcode = (ir_q == IR_IDCODE);
   assign sel_bypass = ~(sel_extest | sel_intest | sel_sample | sel_idcode);

   // ---------------------------------------------------------------
   // Boundary chain tables and capture values
   // ---------------------------------------------------------------
   logic [CHAIN_LEN-1:0] init_vec, cap_vec, chain_q, upd_q;
   logic [N_POS-1:0]     upd_in, upd_out, upd_en, ini_in, ini_out, ini_en;

   for (genvar g = 1; g <= N_POS; g++)
   begin : g_pos
      localparam logic [2:0] INIT = pos_init(g);
      localparam int         IDX  = cell_idx(g, CELL_IN);
      logic                  cin;

      // Intest holds input cells at their constants
      assign cin = sel_intest ? INIT[2] : pin_s2_q[g-1];
      assign init_vec[IDX] = INIT[2];
      assign cap_vec[IDX]  = cin;
      assign upd_in[g-1]   = upd_q[IDX];
      assign ini_in[g-1]   = INIT[2];

      if (is_in_only(g))
      begin : g_in
         assign upd_out[g-1] = 1'b0;
         assign upd_en[g-1]  = 1'b0;
         assign ini_out[g-1] = 1'b0;
         assign ini_en[g-1]  = 1'b0;
      end
      else
      begin : g_io
         localparam int IO = cell_idx(g, CELL_OUT);
         localparam int IE = cell_idx(g, CELL_EN);
         assign init_vec[IO] = INIT[1];
         assign init_vec[IE] = INIT[0];
         // Extest holds output cells at constants; others see the core
         assign cap_vec[IO]  = sel_extest ? INIT[1] : i_core_do[g-1];
         assign cap_vec[IE]  = sel_extest ? INIT[0] : i_core_oe[g-1];
         assign upd_out[g-1] = upd_q[IO];
         assign upd_en[g-1]  = upd_q[IE];
         assign ini_out[g-1] = INIT[1];
         assign ini_en[g-1]  = INIT[0];
      end
   end

   // ---------------------------------------------------------------
   // Data registers
   // ---------------------------------------------------------------
   logic [ID_LEN-1:0] id_q;
   logic              byp_q;

   // Chain and update cells fall back to their constants while the controller
   // rests in reset, so the pads leave test modes from known levels
   always_ff @(posedge i_mclk)
   begin
      if (i_rst || state_q == ST_RESET)
      begin
         chain_q <= init_vec;
         upd_q   <= init_vec;
      end
      else if (tck_rise && (sel_extest || sel_intest || sel_sample))
      begin
         unique case (state_q)
            ST_CAPTURE_DR: chain_q <= cap_vec;
            ST_SHIFT_DR:   chain_q <= {jt_s2_q.tdi, chain_q[CHAIN_LEN-1:1]};
            ST_UPDATE_DR:  upd_q   <= chain_q;
            default:       chain_q <= chain_q;
         endcase
      end
   end

   // Capture reloads the fixed code at every frame; shifted-in data only passes through to data out
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         id_q <= '0;
      else if (tck_rise && sel_idcode)
      begin
         if (state_q == ST_CAPTURE_DR)
            id_q <= {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};
         else if (state_q == ST_SHIFT_DR)
            id_q <= {jt_s2_q.tdi, id_q[ID_LEN-1:1]};
      end
   end

   // Capture clears the stage, so the first bit out of a bypass frame is zero
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         byp_q <= 1'b0;
      else if (tck_rise && sel_bypass)
      begin
         if (state_q == ST_CAPTURE_DR)
            byp_q <= 1'b0;
         else if (state_q == ST_SHIFT_DR)
            byp_q <= jt_s2_q.tdi;
      end
   end

   // ---------------------------------------------------------------
   // Test data output, driven on the falling test clock edge
   // ---------------------------------------------------------------
   logic tdo_sel;

   always_comb
   begin
      if (state_q == ST_SHIFT_IR)
         tdo_sel = ir_sh_q[0];
      else if (sel_idcode)
         tdo_sel = id_q[0];
      else if (sel_bypass)
         tdo_sel = byp_q;
      else
         tdo_sel = chain_q[0];
   end

   // Data out lags the pin's falling edge by two to three system clocks; the
   // far side samples at the next rise, half a test clock later
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         o_tdo    <= tdo_sel;
         o_tdo_oe <= (state_q == ST_SHIFT_DR) || (state_q == ST_SHIFT_IR);
      end
   end

   // ---------------------------------------------------------------
   // Pad and core steering
   // ---------------------------------------------------------------
   // Sample and bypass leave the functional path untouched
   // The reset state hands the pads back to the core, except during power-on reset, which zeroes them
   // Leaving a test mode costs one system clock before the core regains the pads
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_pin_do    <= '0;
         o_pin_oe    <= '0;
         o_core_di   <= '0;
         o_test_mode <= 1'b0;
      end
      else if (sel_extest && state_q != ST_RESET)
      begin
         o_pin_do    <= upd_out;
         o_pin_oe    <= upd_en;
         o_core_di   <= pin_s2_q;
         o_test_mode <= 1'b1;
      end
      else if (sel_intest && state_q != ST_RESET)
      begin
         o_pin_do    <= ini_out;
         o_pin_oe    <= ini_en;
         o_core_di   <= upd_in;
         o_test_mode <= 1'b1;
      end
      else
      begin
         o_pin_do    <= i_core_do;
         o_pin_oe    <= i_core_oe;
         o_core_di   <= pin_s2_q;
         o_test_mode <= 1'b0;
      end
   end

   // Input cell initial constants are unused on the pad side
   logic unused_ini;
   assign unused_ini = ^ini_in;

endmodule : scan_tap

// ==== scan_tap_sva.sv ====
`timescale 1ns/1ps
module scan_tap_sva
   import tap_pkg::*;
(
   input wire logic             i_mclk,     // Clock
   input wire logic             i_rst,      // Reset
   input wire tap_pins_t        i_jtag,     // Test pins
   input wire logic [N_POS-1:0] i_pin_in,   // Pads in
   input wire logic [N_POS-1:0] i_core_do,  // Core data
   input wire logic [N_POS-1:0] i_core_oe,  // Core enable
   input wire logic             o_tdo,      // Data out
   input wire logic             o_tdo_oe,   // Data out enable
   input wire logic [N_POS-1:0] o_pin_do,   // Pad data
   input wire logic [N_POS-1:0] o_pin_oe,   // Pad enable
   input wire logic [N_POS-1:0] o_core_di,  // Core inputs
   input wire logic             o_test_mode // Chain owns pins
);
   logic       tck_q;
   logic [2:0] hi_cnt_q;

   always_ff @(posedge i_mclk) tck_q <= i_jtag.tck;

   // Test clock rises seen with mode select high, saturating
   always_ff @(posedge i_mclk)
      if (i_rst || (i_jtag.tck && !tck_q && !i_jtag.tms)) hi_cnt_q <= 3'h0;
      else if (i_jtag.tck && !tck_q && hi_cnt_q != 3'h7) hi_cnt_q <= hi_cnt_q + 3'h1;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   chk_reset_quiet: assert property (
      $fell(i_rst) |-> !o_test_mode && !o_tdo_oe && !o_tdo)
      else $error("outputs not quiet after reset");
   chk_normal_pass: assert property (
      !o_test_mode && !$past(o_test_mode) && !$past(o_test_mode, 2) && !$past(i_rst)
      |-> o_pin_do == $past(i_core_do) && o_pin_oe == $past(i_core_oe))
      else $error("pads disturbed in normal operation");
   chk_tdo_fall: assert property (
      $changed(o_tdo) |-> !$past(i_jtag.tck) && !$past(i_jtag.tck, 2) && !$past(i_jtag.tck, 3))
      else $error("data out moved outside a low test clock");
   chk_tdo_stands: assert property (
      $changed(o_tdo) |=> $stable(o_tdo)[*8])
      else $error("data out did not stand");
   chk_oe_stands: assert property (
      $rose(o_tdo_oe) |-> !$past(i_jtag.tck, 3) ##0 o_tdo_oe[*8])
      else $error("data out enable timing wrong");
   chk_in_only_idle: assert property (
      o_test_mode && $past(o_test_mode) |-> o_pin_oe[123:120] == 4'h0
      && o_pin_do[123:120] == 4'h0 && o_pin_oe[17:16] == 2'h0)
      else $error("input-only position driven");
   chk_tms_reset: assert property (
      $rose(hi_cnt_q == 3'h5) |-> ##8 !o_test_mode && !o_tdo_oe)
      else $error("mode select high did not reset");
   chk_oe_off_tms: assert property (
      hi_cnt_q >= 3'h2 |-> !o_tdo_oe)
      else $error("shift state after mode select high");
endmodule : scan_tap_sva

bind scan_tap scan_tap_sva i_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_jtag(i_jtag),
   .i_pin_in(i_pin_in), .i_core_do(i_core_do), .i_core_oe(i_core_oe), .o_tdo(o_tdo),
   .o_tdo_oe(o_tdo_oe), .o_pin_do(o_pin_do), .o_pin_oe(o_pin_oe), .o_core_di(o_core_di),
   .o_test_mode(o_test_mode));

// ==== tap_ctl_model.sv ====
`timescale 1ns/1ps
module tap_ctl_model
   import tap_pkg::*;
(
   output tap_pins_t  o_jtag,  // Test clock, mode, data in
   input  wire logic  i_tdo,   // Test data out
   input  wire logic  i_tdo_oe // Test data out enable
);
   localparam int W = CHAIN_LEN + 8;

   // Clock stands low between frames; mode and data rest at pull-up level
   initial o_jtag = 3'b011;

   // One 80 ns test clock; data out is taken at the rise.
   // A released data out reads as the inverse, so a missing enable shows up
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      o_jtag.tms = tms;
      o_jtag.tdi = tdi;
      #40 o_jtag.tck = 1'b1;
      tdo = i_tdo_oe ? i_tdo : ~i_tdo;
      #40 o_jtag.tck = 1'b0;
   endtask : step

   task automatic reset_tap();
      logic d;
      repeat (5) step(1'b1, 1'b1, d);
   endtask : reset_tap

   // From idle or reset: shift n bits least significant first, update, idle
   task automatic scan(input logic ir, input int n, input logic [W-1:0] din,
                       output logic [W-1:0] dout);
      logic d;
      dout = '0;
      step(1'b0, 1'b1, d);
      step(1'b1, 1'b1, d);
      if (ir) step(1'b1, 1'b1, d);
      step(1'b0, 1'b1, d);
      step(1'b0, 1'b1, d);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], d);
         dout[i] = d;
      end
      step(1'b1, 1'b1, d);
      step(1'b0, 1'b1, d);
      o_jtag.tms = 1'b1;
      o_jtag.tdi = 1'b1;
   endtask : scan
endmodule : tap_ctl_model

// ==== scan_tap_tb_top.sv ====
`timescale 1ns/1ps
module scan_tap_tb_top
   import tap_pkg::*;
;
   localparam int          W      = CHAIN_LEN + 8;
   localparam logic [3:0]  T_VER  = 4'h2;    // Arbitrary value
   localparam logic [15:0] T_DEV  = 16'h0F0F; // Arbitrary value
   localparam logic [10:0] T_MAK  = 11'h2A5; // Arbitrary value
   localparam logic [31:0] ID_VAL = {T_VER, T_DEV, T_MAK, 1'b1};
   localparam logic [21:0] P_TST  = {11'h420, 11'h031};
   localparam logic [21:0] P_NRM  = {11'h000, 11'h7FF};
   localparam logic [6:0]  TMS_CAP = 7'h36;   // Idle, instruction capture, update, idle
   localparam logic [9:0]  TMS_PSE = 10'h252; // Data shift, pause, resume, exit

   typedef struct {
      logic [2:0]  code;
      int          len;
      logic        mode;
      logic [6:0]  cap;
      logic [1:0]  upd;
      logic [21:0] pre;
   } row_t;

   logic             i_mclk;
   logic             i_rst;
   tap_pins_t        jtag;
   logic [N_POS-1:0] pin_in, core_do, core_oe, pin_do, pin_oe, core_di;
   logic             tdo, tdo_oe, test_mode, d;
   logic [W-1:0]     din, dout;
   row_t             rows [8];
   int               error_cnt = 0;
   int               checks_done = 0;

   scan_tap #(.ID_VERSION(T_VER), .ID_DEVICE(T_DEV), .ID_MAKER(T_MAK)) i_scan_tap (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_jtag(jtag), .i_pin_in(pin_in),
      .i_core_do(core_do), .i_core_oe(core_oe), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
      .o_pin_do(pin_do), .o_pin_oe(pin_oe), .o_core_di(core_di), .o_test_mode(test_mode));

   tap_ctl_model i_tap_ctl_model (.o_jtag(jtag), .i_tdo(tdo), .i_tdo_oe(tdo_oe));

   always #2.5 i_mclk = ~i_mclk;

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   // Hang guard
   initial
   begin
      #300_000;
      error_cnt++;
      close_out();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      i_mclk  = 1'b0;
      i_rst   = 1'b1;
      pin_in  = '1;
      core_do = '0;
      core_oe = '1;
      din     = {44{8'h5A}};
      rows[0] = '{IR_EXTEST, CHAIN_LEN, 1'b1, 7'h4F, 2'b10, P_TST};
      rows[1] = '{IR_INTEST, CHAIN_LEN, 1'b1, 7'h10, 2'b01, P_TST};
      rows[2] = '{IR_SAMPLE, CHAIN_LEN, 1'b0, 7'h5F, 2'b01, P_NRM};
      rows[3] = '{IR_IDCODE, ID_LEN, 1'b0, ID_VAL[6:0], 2'b01, P_NRM};
      for (int c = 4; c < 8; c++) rows[c] = '{3'(c), 1, 1'b0, 7'h34, 2'b01, P_NRM};
      repeat (5) @(negedge i_mclk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_mclk);
      chk("mode_after_reset", test_mode, 1'b0);
      i_tap_ctl_model.scan(1'b0, ID_LEN, din, dout);
      chk("idcode", dout[31:0], ID_VAL);
      foreach (rows[r])
      begin
         i_tap_ctl_model.reset_tap();
         repeat (8) @(negedge i_mclk);
         chk("mode_reset", test_mode, 1'b0);
         i_tap_ctl_model.scan(1'b1, IR_LEN, W'(rows[r].code), dout);
         chk("ir_capture", dout[2:0], 3'h1);
         repeat (8) @(negedge i_mclk);
         chk("mode", test_mode, rows[r].mode);
         chk("pin_const", {pin_do[10:0], pin_oe[10:0]}, rows[r].pre);
         i_tap_ctl_model.scan(1'b0, rows[r].len + 8, din, dout);
         repeat (8) @(negedge i_mclk);
         chk("capture", dout[6:0], rows[r].cap);
         chk("length", dout[rows[r].len +: 8], 8'h5A);
         chk("update", {pin_do[0], pin_oe[0]}, rows[r].upd);
         if (rows[r].code != IR_EXTEST)
            chk("core_in", core_di[0], rows[r].code != IR_INTEST);
      end
      // Core data reaches the pads untouched outside test modes
      core_do = {31{4'hA}};
      repeat (4) @(negedge i_mclk);
      chk("pass_core", pin_do[123:92], 32'hAAAA_AAAA);
      // Pause in mid shift and resume: no bit lost or repeated
      i_tap_ctl_model.reset_tap();
      for (int i = 0; i < 10; i++) i_tap_ctl_model.step(TMS_PSE[i], 1'b1, d);
      chk("pause_resume", d, ID_VAL[2]);
      // Capture then update of the instruction with no shift selects internal test
      i_tap_ctl_model.reset_tap();
      for (int i = 0; i < 7; i++) i_tap_ctl_model.step(TMS_CAP[i], 1'b1, d);
      repeat (8) @(negedge i_mclk);
      chk("mode_no_shift", test_mode, 1'b1);
      chk("pin_const_int", {pin_do[10:0], pin_oe[10:0]}, P_TST);
      close_out();
   end
endmodule : scan_tap_tb_top
